/* File: logic/fspp_pkg.sv */
package fspp_pkg;
	// fuse byte reset values (0 = programmed)
	localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
	localparam logic [7:0] FUSE_LOW_RST = 8'h62;
	localparam logic [7:0] LOCK_RST = 8'hFF;
	localparam int HI_SERIAL_PROG_BIT = 5;
	localparam int HI_EEPROM_PRESERVE_BIT = 3;
	localparam int LOCK_MEM_A_BIT = 0;
	localparam logic [3:0] CLOCK_SOURCE_RC_8MHZ = 4'h2;
	// action select codes
	localparam logic [1:0] ACT_LOAD_ADDR = 2'h0;
	localparam logic [1:0] ACT_LOAD_DATA = 2'h1;
	localparam logic [1:0] ACT_LOAD_CMD = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// command bytes
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
	localparam logic [7:0] CMD_READ_SIG = 8'h08;
	localparam logic [7:0] CMD_READ_FUSE = 8'h04;
	// signature address space
	localparam logic [7:0] SIG_ADDR_MAKER = 8'h00;
	localparam logic [7:0] SIG_ADDR_SIZE = 8'h01;
	localparam logic [7:0] SIG_ADDR_PART = 8'h02;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_MIN_NS = 250;
	localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CYC = 16;
	// apb register offsets of the programmer
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_RDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
endpackage

/* File: logic/fspp_if.sv */
interface fspp_if;
	logic crystal_in_strobe;
	logic action_select_0;
	logic action_select_1;
	logic byte_select_a;
	logic byte_select_b;
	logic page_load_strobe;
	logic wr_b;
	logic oe_b;
	logic ready_busy_out;
	logic [7:0] data_prog;
	logic [7:0] data_dev;
	logic data_dev_oe;
	wire [7:0] data_bus = data_dev_oe ? data_dev : data_prog;
	modport device (input crystal_in_strobe, action_select_0, action_select_1, byte_select_a,
		byte_select_b, page_load_strobe, wr_b, oe_b, data_bus,
		output ready_busy_out, data_dev, data_dev_oe);
	modport programmer (output crystal_in_strobe, action_select_0, action_select_1,
		byte_select_a, byte_select_b, page_load_strobe, wr_b, oe_b, data_prog,
		input ready_busy_out, data_bus);
endinterface

/* File: logic/fspp_device.sv */
module fspp_device #(
	parameter logic [7:0] SIG_MAKER = 8'hA5, // arbitrary
	parameter logic [7:0] SIG_SIZE = 8'h5A, // arbitrary
	parameter logic [7:0] SIG_PART = 8'h3C, // arbitrary
	parameter logic [7:0] CAL_BYTE = 8'h80
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic prog_mode_in,
	input wire logic serial_access_in,
	fspp_if.device pins,
	output logic [7:0] active_fuse_low_out,
	output logic [7:0] active_fuse_high_out,
	output logic [7:0] active_fuse_ext_out,
	output logic [7:0] rc_osc_calibration_reg_out,
	output logic eeprom_erase_out,
	output logic flash_erase_out,
	output logic [7:0] page_data_out,
	output logic page_latch_out
);
	typedef struct packed {
		logic [7:0] fuse_low;
		logic [7:0] fuse_high;
		logic [7:0] fuse_ext;
		logic [7:0] act_low;
		logic [7:0] act_high;
		logic [7:0] act_ext;
		logic [7:0] lock;
		logic [7:0] cmd;
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
		logic [7:0] data_lo;
		logic [7:0] data_hi;
		logic [7:0] rc_osc_calibration_reg;
		logic [7:0] dout;
		logic xtal_d;
		logic wr_d;
		logic oe_d;
		logic pgl_d;
		logic prog_d;
		logic ee_erase;
		logic fl_erase;
		logic page_latch;
		logic [7:0] busy_cnt;
	} fspp_dev_state_t;
	fspp_dev_state_t st_r, st_nxt;
	logic xtal_rise, wr_fall, oe_fall, pgl_rise;
	assign xtal_rise = pins.crystal_in_strobe & ~st_r.xtal_d;
	assign wr_fall = ~pins.wr_b & st_r.wr_d;
	assign oe_fall = ~pins.oe_b & st_r.oe_d;
	assign pgl_rise = pins.page_load_strobe & ~st_r.pgl_d;
	always_comb begin
		logic [1:0] act;
		logic [7:0] wval;
		act = {pins.action_select_1, pins.action_select_0};
		wval = pins.data_bus;
		st_nxt = st_r;
		st_nxt.xtal_d = pins.crystal_in_strobe;
		st_nxt.wr_d = pins.wr_b;
		st_nxt.oe_d = pins.oe_b;
		st_nxt.pgl_d = pins.page_load_strobe;
		st_nxt.prog_d = prog_mode_in;
		st_nxt.ee_erase = 1'b0;
		st_nxt.fl_erase = 1'b0;
		st_nxt.page_latch = 1'b0;
		if (st_r.busy_cnt != 8'h00) begin
			st_nxt.busy_cnt = st_r.busy_cnt - 8'h01;
		end
		// capture on entry to and exit from programming mode
		if (prog_mode_in != st_r.prog_d) begin
			st_nxt.act_low = st_r.fuse_low;
			st_nxt.act_high = st_r.fuse_high;
			st_nxt.act_ext = st_r.fuse_ext;
		end
		// preserve bit follows the stored fuse at once
		st_nxt.act_high[fspp_pkg::HI_EEPROM_PRESERVE_BIT] =
			st_r.fuse_high[fspp_pkg::HI_EEPROM_PRESERVE_BIT];
		if (prog_mode_in && xtal_rise) begin
			case (act)
				fspp_pkg::ACT_LOAD_ADDR: begin
					if (pins.byte_select_a) begin
						st_nxt.addr_hi = wval;
					end else begin
						st_nxt.addr_lo = wval;
					end
				end
				fspp_pkg::ACT_LOAD_DATA: begin
					if (pins.byte_select_a) begin
						st_nxt.data_hi = wval;
					end else begin
						st_nxt.data_lo = wval;
					end
				end
				fspp_pkg::ACT_LOAD_CMD: st_nxt.cmd = wval;
				default: ;
			endcase
		end
		if (prog_mode_in && pgl_rise) begin
			st_nxt.page_latch = 1'b1;
		end
		if (prog_mode_in && wr_fall && st_r.busy_cnt == 8'h00) begin
			case (st_r.cmd)
				fspp_pkg::CMD_WRITE_FUSE: begin
					if (st_r.lock[fspp_pkg::LOCK_MEM_A_BIT]) begin
						if (pins.byte_select_a && !pins.byte_select_b) begin
							st_nxt.fuse_high = wval;
							if (serial_access_in) begin
								st_nxt.fuse_high[fspp_pkg::HI_SERIAL_PROG_BIT] =
									st_r.fuse_high[fspp_pkg::HI_SERIAL_PROG_BIT];
							end
						end else if (pins.byte_select_b) begin
							st_nxt.fuse_ext = wval;
						end else begin
							st_nxt.fuse_low = wval;
						end
						st_nxt.busy_cnt = 8'(fspp_pkg::BUSY_CYC);
					end
				end
				fspp_pkg::CMD_WRITE_LOCK: begin
					st_nxt.lock = st_r.lock & wval;
					st_nxt.busy_cnt = 8'(fspp_pkg::BUSY_CYC);
				end
				fspp_pkg::CMD_CHIP_ERASE: begin
					// fuses untouched, lock bits return to unprogrammed
					st_nxt.lock = fspp_pkg::LOCK_RST;
					st_nxt.fl_erase = 1'b1;
					st_nxt.ee_erase = st_r.fuse_high[fspp_pkg::HI_EEPROM_PRESERVE_BIT];
					st_nxt.busy_cnt = 8'(fspp_pkg::BUSY_CYC);
				end
				default: ;
			endcase
		end
		if (oe_fall) begin
			st_nxt.dout = 8'hFF;
			if (st_r.cmd == fspp_pkg::CMD_READ_SIG) begin
				if (pins.byte_select_a && st_r.addr_lo == fspp_pkg::SIG_ADDR_MAKER) begin
					st_nxt.dout = st_r.rc_osc_calibration_reg;
				end else if (st_r.addr_lo == fspp_pkg::SIG_ADDR_MAKER) begin
					st_nxt.dout = SIG_MAKER;
				end else if (st_r.addr_lo == fspp_pkg::SIG_ADDR_SIZE) begin
					st_nxt.dout = SIG_SIZE;
				end else if (st_r.addr_lo == fspp_pkg::SIG_ADDR_PART) begin
					st_nxt.dout = SIG_PART;
				end
			end else if (st_r.cmd == fspp_pkg::CMD_READ_FUSE) begin
				// stored bits, 0 = programmed; high fuse bit 5 reads 1 under serial access
				if (pins.byte_select_a && pins.byte_select_b) begin
					st_nxt.dout = st_r.fuse_high;
				end else if (pins.byte_select_a) begin
					st_nxt.dout = st_r.lock;
				end else if (pins.byte_select_b) begin
					st_nxt.dout = st_r.fuse_ext;
				end else begin
					st_nxt.dout = st_r.fuse_low;
				end
				if (serial_access_in && pins.byte_select_a && pins.byte_select_b) begin
					st_nxt.dout[fspp_pkg::HI_SERIAL_PROG_BIT] = 1'b1;
				end
			end
		end
		if (!clk_en_in) begin
			st_nxt = st_r;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			st_r.fuse_low <= fspp_pkg::FUSE_LOW_RST;
			st_r.fuse_high <= fspp_pkg::FUSE_HIGH_RST;
			st_r.fuse_ext <= fspp_pkg::FUSE_EXT_RST;
			// power-up capture of the stored fuses
			st_r.act_low <= fspp_pkg::FUSE_LOW_RST;
			st_r.act_high <= fspp_pkg::FUSE_HIGH_RST;
			st_r.act_ext <= fspp_pkg::FUSE_EXT_RST;
			st_r.lock <= fspp_pkg::LOCK_RST;
			st_r.cmd <= 8'h00;
			st_r.addr_lo <= 8'h00;
			st_r.addr_hi <= 8'h00;
			st_r.data_lo <= 8'h00;
			st_r.data_hi <= 8'h00;
			st_r.rc_osc_calibration_reg <= CAL_BYTE;
			st_r.dout <= 8'h00;
			st_r.xtal_d <= 1'b0;
			st_r.wr_d <= 1'b1;
			st_r.oe_d <= 1'b1;
			st_r.pgl_d <= 1'b0;
			st_r.prog_d <= 1'b0;
			st_r.ee_erase <= 1'b0;
			st_r.fl_erase <= 1'b0;
			st_r.page_latch <= 1'b0;
			st_r.busy_cnt <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign pins.ready_busy_out = (st_r.busy_cnt == 8'h00);
	assign pins.data_dev = st_r.dout;
	assign pins.data_dev_oe = ~pins.oe_b & ~st_r.oe_d;
	assign active_fuse_low_out = st_r.act_low;
	assign active_fuse_high_out = st_r.act_high;
	assign active_fuse_ext_out = st_r.act_ext;
	assign rc_osc_calibration_reg_out = st_r.rc_osc_calibration_reg;
	assign eeprom_erase_out = st_r.ee_erase;
	assign flash_erase_out = st_r.fl_erase;
	assign page_data_out = pins.byte_select_b ? st_r.data_hi : st_r.data_lo;
	assign page_latch_out = st_r.page_latch;
endmodule // fspp_device

/* File: logic/fspp_programmer.sv */
// apb-controlled parallel programmer
module fspp_programmer (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	fspp_if.programmer pins
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_DONE} fspp_pst_t;
	typedef struct packed {
		fspp_pst_t st;
		logic [1:0] op;
		logic [1:0] act;
		logic bsa;
		logic bsb;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [7:0] cnt;
		logic xtal;
		logic wr_b;
		logic oe_b;
		logic pgl;
		logic drive;
		logic [31:0] prdata;
	} fspp_prog_state_t;
	fspp_prog_state_t s_r, s_nxt;
	logic acc;
	assign acc = psel_in & penable_in;
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			ST_IDLE: begin
				if (acc && pwrite_in && paddr_in == fspp_pkg::REG_WDATA) begin
					s_nxt.wdata = pwdata_in[7:0];
				end
				if (acc && pwrite_in && paddr_in == fspp_pkg::REG_CTRL && pwdata_in[8]) begin
					// ctrl: [1:0] op 0 xtal 1 wr 2 oe 3 page_load_strobe, [3:2] act, [4] bsa, [5] bsb
					s_nxt.op = pwdata_in[1:0];
					s_nxt.act = pwdata_in[3:2];
					s_nxt.bsa = pwdata_in[4];
					s_nxt.bsb = pwdata_in[5];
					s_nxt.drive = (pwdata_in[1:0] != 2'h2);
					s_nxt.cnt = 8'(fspp_pkg::STROBE_MIN_CYC);
					s_nxt.st = ST_SETUP;
				end
			end
			ST_SETUP: begin
				s_nxt.st = ST_PULSE;
				case (s_r.op)
					2'h0: s_nxt.xtal = 1'b1;
					2'h1: s_nxt.wr_b = 1'b0;
					2'h2: s_nxt.oe_b = 1'b0;
					default: s_nxt.pgl = 1'b1;
				endcase
			end
			ST_PULSE: begin
				// strobe stays asserted for the full minimum width
				if (s_r.cnt <= 8'h01) begin
					s_nxt.rdata = pins.data_bus;
					s_nxt.xtal = 1'b0;
					s_nxt.wr_b = 1'b1;
					s_nxt.oe_b = 1'b1;
					s_nxt.pgl = 1'b0;
					s_nxt.cnt = 8'(fspp_pkg::STROBE_MIN_CYC);
					s_nxt.st = ST_HOLD;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			ST_HOLD: begin
				if (s_r.cnt <= 8'h01) begin
					s_nxt.st = ST_DONE;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			default: begin
				s_nxt.drive = 1'b0;
				s_nxt.st = ST_IDLE;
			end
		endcase
		// read word taken in the setup cycle so it stands through the access phase
		if (psel_in && !penable_in) begin
			s_nxt.prdata = 32'h0000_0000;
			if (paddr_in == fspp_pkg::REG_WDATA) begin
				s_nxt.prdata = {24'h00_0000, s_r.wdata};
			end else if (paddr_in == fspp_pkg::REG_RDATA) begin
				s_nxt.prdata = {24'h00_0000, s_r.rdata};
			end else if (paddr_in == fspp_pkg::REG_STATUS) begin
				s_nxt.prdata = {30'h0, pins.ready_busy_out, s_r.st != ST_IDLE};
			end
		end
		if (!clk_en_in) begin
			s_nxt = s_r;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			s_r.st <= ST_IDLE;
			s_r.op <= 2'h0;
			s_r.act <= fspp_pkg::ACT_IDLE;
			s_r.bsa <= 1'b0;
			s_r.bsb <= 1'b0;
			s_r.wdata <= 8'h00;
			s_r.rdata <= 8'h00;
			s_r.cnt <= 8'h00;
			s_r.xtal <= 1'b0;
			s_r.wr_b <= 1'b1;
			s_r.oe_b <= 1'b1;
			s_r.pgl <= 1'b0;
			s_r.drive <= 1'b0;
			s_r.prdata <= 32'h0000_0000;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign prdata_out = s_r.prdata;
	assign pready_out = 1'b1;
	assign pslverr_out = acc && paddr_in != fspp_pkg::REG_CTRL && paddr_in != fspp_pkg::REG_WDATA
		&& paddr_in != fspp_pkg::REG_RDATA && paddr_in != fspp_pkg::REG_STATUS;
	assign pins.crystal_in_strobe = s_r.xtal;
	assign pins.action_select_0 = s_r.act[0];
	assign pins.action_select_1 = s_r.act[1];
	assign pins.byte_select_a = s_r.bsa;
	assign pins.byte_select_b = s_r.bsb;
	assign pins.page_load_strobe = s_r.pgl;
	assign pins.wr_b = s_r.wr_b;
	assign pins.oe_b = s_r.oe_b;
	// bus released during reads so the device may drive it
	assign pins.data_prog = s_r.drive ? s_r.wdata : 8'h00;
endmodule // fspp_programmer

/* File: verification/fspp_monitor.sv */
module fspp_monitor #(
	parameter logic [7:0] SIG_MAKER = 8'hA5, // arbitrary
	parameter logic [7:0] SIG_SIZE = 8'h5A, // arbitrary
	parameter logic [7:0] SIG_PART = 8'h3C, // arbitrary
	parameter logic [7:0] CAL_BYTE = 8'h80
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic crystal_in_strobe,
	input wire logic action_select_0,
	input wire logic action_select_1,
	input wire logic byte_select_a,
	input wire logic byte_select_b,
	input wire logic wr_b,
	input wire logic oe_b,
	input wire logic ready_busy_out,
	input wire logic [7:0] data_bus,
	input wire logic [7:0] data_dev,
	input wire logic data_dev_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] addr;
		logic xtal;
		logic [4:0] busy_cnt;
	} fspp_mon_t;
	fspp_mon_t st_r;
	fspp_mon_t st_nxt;
	logic [7:0] sig_exp;
	logic sig_ok;
	// shadow of the loaded command and low address, as the device should see them
	always_comb begin
		st_nxt = st_r;
		st_nxt.xtal = crystal_in_strobe;
		if (crystal_in_strobe && !st_r.xtal) begin
			if ({action_select_1, action_select_0} == fspp_pkg::ACT_LOAD_CMD) begin
				st_nxt.cmd = data_bus;
			end
			if ({action_select_1, action_select_0} == fspp_pkg::ACT_LOAD_ADDR && !byte_select_a) begin
				st_nxt.addr = data_bus;
			end
		end
		st_nxt.busy_cnt = ready_busy_out ? 5'h00 : st_r.busy_cnt + 5'h01;
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign sig_ok = !byte_select_b && (byte_select_a ? st_r.addr == 8'h00 : st_r.addr <= 8'h02);
	assign sig_exp = byte_select_a ? CAL_BYTE : (st_r.addr == 8'h00 ? SIG_MAKER :
		(st_r.addr == 8'h01 ? SIG_SIZE : SIG_PART));
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);
	a_drive_needs_oe: assert property (data_dev_oe |-> !$past(oe_b))
		else $error("bus driven without output enable");
	a_read_drives_bus: assert property ($fell(oe_b) && (st_r.cmd == fspp_pkg::CMD_READ_SIG ||
		st_r.cmd == fspp_pkg::CMD_READ_FUSE) |-> ##[1:2] data_dev_oe)
		else $error("read strobe did not drive bus");
	a_bus_released: assert property (oe_b && $past(oe_b) |-> !data_dev_oe)
		else $error("bus still driven after output enable");
	a_write_goes_busy: assert property ($fell(wr_b) && ready_busy_out &&
		(st_r.cmd == fspp_pkg::CMD_CHIP_ERASE || st_r.cmd == fspp_pkg::CMD_WRITE_LOCK)
		|-> ##[1:2] !ready_busy_out)
		else $error("write strobe did not start busy");
	a_busy_length: assert property ($rose(ready_busy_out) |-> st_r.busy_cnt == fspp_pkg::BUSY_CYC)
		else $error("busy period has wrong length");
	a_busy_bound: assert property (st_r.busy_cnt <= fspp_pkg::BUSY_CYC)
		else $error("busy period too long");
	a_busy_from_write: assert property ($fell(ready_busy_out) |-> !$past(wr_b))
		else $error("busy without write strobe");
	a_reset_idle: assert property ($rose(rst_b_in) |-> ready_busy_out && !data_dev_oe)
		else $error("not idle after reset");
	a_sig_value: assert property (data_dev_oe && st_r.cmd == fspp_pkg::CMD_READ_SIG && sig_ok
		|-> data_dev == sig_exp)
		else $error("wrong signature or calibration byte");
	c_fuse_write: cover property ($fell(wr_b) && st_r.cmd == fspp_pkg::CMD_WRITE_FUSE);
	c_sig_read: cover property (data_dev_oe && st_r.cmd == fspp_pkg::CMD_READ_SIG);
	c_busy_done: cover property ($rose(ready_busy_out));
endmodule // fspp_monitor

/* File: verification/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SIG [3] = '{8'h4D, 8'hB2, 8'h17}; // arbitrary
	localparam logic [7:0] CAL = 8'h6E;
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic prog_mode = 1'b0;
	logic ser = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, ee_er, fl_er, pg_lat;
	logic [7:0] f_lo, f_hi, f_ext, osc, pg_dat;
	int errors = 0;
	int compares = 0;
	int n_ee = 0;
	int n_fl = 0;
	int n_pl = 0;
	int n_busy = 0;
	fspp_if link();
	fspp_device #(.SIG_MAKER(SIG[0]), .SIG_SIZE(SIG[1]), .SIG_PART(SIG[2]), .CAL_BYTE(CAL))
		fspp_device_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
		.prog_mode_in(prog_mode), .serial_access_in(ser), .pins(link.device),
		.active_fuse_low_out(f_lo), .active_fuse_high_out(f_hi), .active_fuse_ext_out(f_ext),
		.rc_osc_calibration_reg_out(osc), .eeprom_erase_out(ee_er), .flash_erase_out(fl_er),
		.page_data_out(pg_dat), .page_latch_out(pg_lat));
	fspp_programmer fspp_programmer_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.clk_en_in(1'b1), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .pins(link.programmer));
	fspp_monitor #(.SIG_MAKER(SIG[0]), .SIG_SIZE(SIG[1]), .SIG_PART(SIG[2]), .CAL_BYTE(CAL))
		fspp_monitor_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.crystal_in_strobe(link.crystal_in_strobe), .action_select_0(link.action_select_0),
		.action_select_1(link.action_select_1), .byte_select_a(link.byte_select_a),
		.byte_select_b(link.byte_select_b), .wr_b(link.wr_b), .oe_b(link.oe_b),
		.ready_busy_out(link.ready_busy_out), .data_bus(link.data_bus),
		.data_dev(link.data_dev), .data_dev_oe(link.data_dev_oe));
	always #5 clk_sys_in = ~clk_sys_in;
	// pulses counted mid-cycle, clear of the launching edge
	always @(negedge clk_sys_in) begin
		if (ee_er === 1'b1) n_ee++;
		if (fl_er === 1'b1) n_fl++;
		if (pg_lat === 1'b1) n_pl++;
		if (link.ready_busy_out === 1'b0) n_busy++;
	end
	task automatic end_of_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chki(input int got, input int exp);
		compares++;
		if (got != exp) begin
			errors++;
			$display("BAD %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do begin
			@(posedge clk_sys_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	// one strobe: byte, then control word with go bit, then wait for both ends idle
	task automatic op(input logic [1:0] code, input logic [1:0] act, input logic a, input logic b,
		input logic [7:0] d);
		int n = 0;
		apb(1'b1, fspp_pkg::REG_WDATA, {24'h0, d});
		apb(1'b1, fspp_pkg::REG_CTRL, {23'h0, 1'b1, 2'b00, b, a, act, code});
		do begin
			apb(1'b0, fspp_pkg::REG_STATUS, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 200);
		chki(int'(n < 200), 1);
	endtask
	task automatic cmd(input logic [7:0] c);
		op(2'd0, fspp_pkg::ACT_LOAD_CMD, 1'b0, 1'b0, c);
	endtask
	task automatic rdb(input logic a, input logic b, input logic [7:0] exp);
		op(2'd2, fspp_pkg::ACT_IDLE, a, b, 8'h00);
		apb(1'b0, fspp_pkg::REG_RDATA, 32'h0);
		chk8(rd[7:0], exp);
	endtask
	task automatic wfuse(input logic a, input logic b, input logic [7:0] v);
		cmd(fspp_pkg::CMD_WRITE_FUSE);
		op(2'd0, fspp_pkg::ACT_LOAD_DATA, 1'b0, 1'b0, v);
		op(2'd1, fspp_pkg::ACT_IDLE, a, b, v);
	endtask
	task automatic toggle_mode();
		prog_mode <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		prog_mode <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
	endtask
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		@(negedge clk_sys_in);
		chk8(f_lo, fspp_pkg::FUSE_LOW_RST);
		chk8(f_hi, fspp_pkg::FUSE_HIGH_RST);
		chk8(f_ext, fspp_pkg::FUSE_EXT_RST);
		chk8(osc, CAL);
		chk8({4'h0, f_lo[3:0]}, {4'h0, fspp_pkg::CLOCK_SOURCE_RC_8MHZ});
		@(posedge clk_sys_in);
		apb(1'b0, 8'h10, 32'h0);
		chk8({7'h0, err}, 8'h01);
		prog_mode <= 1'b1;
		cmd(fspp_pkg::CMD_READ_SIG);
		foreach (SIG[i]) begin
			op(2'd0, fspp_pkg::ACT_LOAD_ADDR, 1'b0, 1'b0, 8'(i));
			rdb(1'b0, 1'b0, SIG[i]);
		end
		op(2'd0, fspp_pkg::ACT_LOAD_ADDR, 1'b0, 1'b0, 8'h00);
		rdb(1'b1, 1'b0, CAL);
		cmd(fspp_pkg::CMD_READ_FUSE);
		rdb(1'b0, 1'b0, fspp_pkg::FUSE_LOW_RST);
		rdb(1'b1, 1'b1, fspp_pkg::FUSE_HIGH_RST);
		rdb(1'b0, 1'b1, fspp_pkg::FUSE_EXT_RST);
		rdb(1'b1, 1'b0, fspp_pkg::LOCK_RST);
		wfuse(1'b0, 1'b0, 8'h5A);
		chki(n_busy, fspp_pkg::BUSY_CYC);
		wfuse(1'b1, 1'b0, 8'h90);
		chk8(f_hi, 8'h91);
		chk8(f_lo, fspp_pkg::FUSE_LOW_RST);
		ser <= 1'b1;
		wfuse(1'b1, 1'b0, 8'hB0);
		ser <= 1'b0;
		cmd(fspp_pkg::CMD_READ_FUSE);
		rdb(1'b0, 1'b0, 8'h5A);
		rdb(1'b1, 1'b1, 8'h90);
		cmd(fspp_pkg::CMD_CHIP_ERASE);
		op(2'd1, fspp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
		chki(n_fl, 1);
		chki(n_ee, 0);
		cmd(fspp_pkg::CMD_READ_FUSE);
		rdb(1'b0, 1'b0, 8'h5A);
		toggle_mode();
		chk8(f_lo, 8'h5A);
		chk8(f_hi, 8'h90);
		cmd(fspp_pkg::CMD_WRITE_LOCK);
		op(2'd0, fspp_pkg::ACT_LOAD_DATA, 1'b0, 1'b0, 8'hFE);
		op(2'd1, fspp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'hFE);
		wfuse(1'b0, 1'b0, 8'h00);
		cmd(fspp_pkg::CMD_READ_FUSE);
		rdb(1'b0, 1'b0, 8'h5A);
		cmd(fspp_pkg::CMD_READ_SIG);
		op(2'd0, fspp_pkg::ACT_LOAD_ADDR, 1'b0, 1'b0, 8'h02);
		op(2'd0, fspp_pkg::ACT_IDLE, 1'b0, 1'b0, fspp_pkg::CMD_READ_FUSE);
		rdb(1'b0, 1'b0, SIG[2]);
		cmd(fspp_pkg::CMD_CHIP_ERASE);
		op(2'd1, fspp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
		wfuse(1'b1, 1'b0, 8'h99);
		toggle_mode();
		chk8(f_hi, 8'h99);
		cmd(fspp_pkg::CMD_CHIP_ERASE);
		op(2'd1, fspp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
		chki(n_ee, 1);
		op(2'd0, fspp_pkg::ACT_LOAD_DATA, 1'b0, 1'b0, 8'h3C);
		op(2'd3, fspp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h3C);
		chk8(pg_dat, 8'h3C);
		chki(n_pl, 1);
		end_of_test();
	end
endmodule // testbench
